// ===== src/uefp_top.sv
/*
 * uart event flags and clear-to-send publish, with an apb register slave
 * and one level interrupt.
 * assumes: event inputs are one-cycle pulses from the byte engine, cts_n
 * is already synchronous to clk, apb master follows the usual protocol.
 */
// Function
// R1 - set end-of-transmission flag after last byte
// R2 - set receive-started flag on receiver start
// R3 - set transmit-started flag on transmitter start
// R4 - publish cts on channel from index field
// R5 - publish only while enable bit 31 set
// R6 - error, timeout, tx-stopped flags sticky until cleared
// R7 - cts event when flow-control input falls low
`timescale 1ns/1ps
`default_nettype none

module uefp_top
    import uefp_pkg::*;
#(
    parameter int NUM_CH = `UEFP_NUM_CHANNELS
) (
    // clock and reset
    input  wire logic               clk,
    input  wire logic               srst,
    // apb slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [31:0]        paddr,
    input  wire logic [31:0]        pwdata,
    input  wire logic [3:0]         pstrb,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    // events from the byte engine
    input  wire logic               tx_last_byte_done,
    input  wire logic               rx_error,
    input  wire logic               rx_timeout,
    input  wire logic               rx_started,
    input  wire logic               tx_started,
    input  wire logic               tx_stopped,
    // flow control from the remote side
    input  wire logic               cts_n,
    // interconnect and interrupt
    output logic      [NUM_CH-1:0]  channel_pulse,
    output logic                    irq
);
    localparam int NEV = `UEFP_NUM_EVENTS;

    logic [NEV-1:0] ev_pulse;
    logic [NEV-1:0] flag_clr;
    logic [NEV-1:0] flags;
    logic [NEV-1:0] mask_reg;
    logic [31:0]    pub_reg;
    logic           cts_n_reg;
    logic           cts_event;
    logic           wr_fire;
    logic           rd_fire;
    logic           addr_ok;
    logic [31:0]    rd_data;
    logic [11:0]    offs;

    // address decode shared by read and write paths
    function automatic logic [3:0] uefp_decode(input logic [31:0] a);
        logic [3:0] idx;
        idx = 4'hf;
        if (a[31:12] == 20'h0) begin
            case (a[11:0])
                `UEFP_OFF_TX_END:      idx = 4'h0;
                `UEFP_OFF_ERROR:       idx = 4'h1;
                `UEFP_OFF_RX_TIMEOUT:  idx = 4'h2;
                `UEFP_OFF_RX_STARTED:  idx = 4'h3;
                `UEFP_OFF_TX_STARTED:  idx = 4'h4;
                `UEFP_OFF_TX_STOPPED:  idx = 4'h5;
                `UEFP_OFF_CTS_FLAG:    idx = 4'h6;
                `UEFP_OFF_CTS_PUBLISH: idx = 4'h8;
                `UEFP_OFF_INT_MASK:    idx = 4'h9;
                `UEFP_OFF_INT_STATUS:  idx = 4'ha;
                default:               idx = 4'hf;
            endcase
        end
        return idx;
    endfunction

    // cts event: falling edge of the flow-control input
    always_ff @(posedge clk) begin
        if (srst) begin
            cts_n_reg <= 1'b1;
        end else begin
            cts_n_reg <= cts_n;
        end
    end
    assign cts_event = cts_n_reg && !cts_n; // [R7]

    always_comb begin
        ev_pulse                     = '0;
        ev_pulse[UEFP_EV_TX_END]     = tx_last_byte_done; // [R1]
        ev_pulse[UEFP_EV_ERROR]      = rx_error;          // [R6]
        ev_pulse[UEFP_EV_RX_TIMEOUT] = rx_timeout;        // [R6]
        ev_pulse[UEFP_EV_RX_STARTED] = rx_started;        // [R2]
        ev_pulse[UEFP_EV_TX_STARTED] = tx_started;        // [R3]
        ev_pulse[UEFP_EV_TX_STOPPED] = tx_stopped;        // [R6]
        ev_pulse[UEFP_EV_CTS]        = cts_event;
    end

    // apb: zero wait states, one access cycle per transfer
    assign pready  = 1'b1;
    assign offs    = paddr[11:0];
    assign addr_ok = (uefp_decode(paddr) != 4'hf) && (paddr[1:0] == 2'b00);
    assign wr_fire = psel && penable && pwrite && addr_ok;
    assign rd_fire = psel && penable && !pwrite;

    // pslverr is combinational against the access phase of an unmapped address
    assign pslverr = psel && penable && !addr_ok;

    // writing 0 to an event register, or 1 to its status bit, clears it
    always_comb begin
        logic [3:0] idx;
        idx      = uefp_decode(paddr);
        flag_clr = '0;
        if (wr_fire && pstrb[0]) begin
            if (idx < 4'h7 && !pwdata[0]) begin
                flag_clr[idx[2:0]] = 1'b1; // [R6]
            end else if (idx == 4'ha) begin
                flag_clr = pwdata[NEV-1:0];
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < NEV; g++) begin : g_flag
            uefp_event_flag u_flag (
                .clk       (clk),
                .srst      (srst),
                .set_pulse (ev_pulse[g]),
                .clr_pulse (flag_clr[g]),
                .flag      (flags[g])
            );
        end
    endgenerate

    // publish configuration, byte-lane writable
    always_ff @(posedge clk) begin
        if (srst) begin
            pub_reg <= `UEFP_PUB_RESET;
        end else if (wr_fire && offs == `UEFP_OFF_CTS_PUBLISH) begin
            for (int b = 0; b < 4; b++) begin
                if (pstrb[b]) begin
                    pub_reg[8*b +: 8] <= pwdata[8*b +: 8];
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            mask_reg <= `UEFP_MASK_RESET;
        end else if (wr_fire && offs == `UEFP_OFF_INT_MASK && pstrb[0]) begin
            mask_reg <= pwdata[NEV-1:0];
        end
    end

    uefp_cts_publish #(
        .NUM_CH (NUM_CH),
        .CH_W   (`UEFP_CHANNEL_INDEX_W)
    ) u_pub (
        .clk           (clk),
        .srst          (srst),
        .pub_en        (pub_reg[`UEFP_PUB_EN_BIT]),                       // [R5]
        .channel_index (pub_reg[`UEFP_CHANNEL_INDEX_LSB +: `UEFP_CHANNEL_INDEX_W]),       // [R4]
        .cts_event     (cts_event),
        .channel_pulse (channel_pulse)
    );

    // read mux; reserved bits read as zero, except bits 30:4 of the publish register, which read back as written
    always_comb begin
        logic [3:0] idx;
        idx     = uefp_decode(paddr);
        rd_data = 32'h0000_0000;
        case (idx)
            4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6:
                rd_data = {31'h0, flags[idx[2:0]]};
            4'h8:    rd_data = pub_reg;
            4'h9:    rd_data = {{(32-NEV){1'b0}}, mask_reg};
            4'ha:    rd_data = {{(32-NEV){1'b0}}, flags};
            default: rd_data = 32'h0000_0000;
        endcase
    end

    // read data registered at the end of the setup phase, held until the next read
    always_ff @(posedge clk) begin
        if (srst) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rd_data;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(flags & mask_reg);
        end
    end

    logic unused_rd;
    assign unused_rd = rd_fire;
endmodule

`default_nettype wire

// ===== src/uefp_defines.svh
/*
 * register offsets, field positions, reset values and counts of the
 * uart event-flag and publish block.
 * assumes: included by bare name from the package only.
 */
`ifndef UEFP_DEFINES_SVH
`define UEFP_DEFINES_SVH

`define UEFP_OFF_CTS_FLAG      12'h100
`define UEFP_OFF_TX_END        12'h120
`define UEFP_OFF_ERROR         12'h124
`define UEFP_OFF_RX_TIMEOUT    12'h144
`define UEFP_OFF_RX_STARTED    12'h14c
`define UEFP_OFF_TX_STARTED    12'h150
`define UEFP_OFF_TX_STOPPED    12'h158
`define UEFP_OFF_CTS_PUBLISH   12'h180
`define UEFP_OFF_INT_MASK      12'h300
`define UEFP_OFF_INT_STATUS    12'h304

`define UEFP_PUB_EN_BIT        31
`define UEFP_CHANNEL_INDEX_LSB         0
`define UEFP_CHANNEL_INDEX_W           4
`define UEFP_PUB_RESET         32'h0000_0000
`define UEFP_FLAG_RESET        1'b0
`define UEFP_MASK_RESET        7'h00
`define UEFP_NUM_EVENTS        7
`define UEFP_NUM_CHANNELS      16
`define UEFP_ADDR_W            12

`endif

// ===== src/uefp_pkg.sv
/*
 * types shared by the event-flag and publish block.
 * assumes: uefp_defines.svh is on the include path.
 */
`include "uefp_defines.svh"

package uefp_pkg;
    // index of each event in the status and mask vectors
    typedef enum logic [2:0] {
        UEFP_EV_TX_END     = 3'h0,
        UEFP_EV_ERROR      = 3'h1,
        UEFP_EV_RX_TIMEOUT = 3'h2,
        UEFP_EV_RX_STARTED = 3'h3,
        UEFP_EV_TX_STARTED = 3'h4,
        UEFP_EV_TX_STOPPED = 3'h5,
        UEFP_EV_CTS        = 3'h6
    } uefp_event_t;

    typedef enum logic [1:0] {
        UEFP_APB_IDLE   = 2'b00,
        UEFP_APB_SETUP  = 2'b01,
        UEFP_APB_ACCESS = 2'b11
    } uefp_apb_state_t;
endpackage

// ===== src/uefp_event_flag.sv
/*
 * one sticky event flag: set by a hardware pulse, cleared by software.
 * assumes: set and clear are single-cycle pulses in the clk domain.
 */
`timescale 1ns/1ps
`default_nettype none

module uefp_event_flag
    import uefp_pkg::*;
(
    // clock and reset
    input  wire logic clk,
    input  wire logic srst,
    // control
    input  wire logic set_pulse,
    input  wire logic clr_pulse,
    // state
    output logic      flag
);
    // set wins over a clear in the same cycle so no event is lost
    always_ff @(posedge clk) begin
        if (srst) begin
            flag <= `UEFP_FLAG_RESET;
        end else if (set_pulse) begin
            flag <= 1'b1;
        end else if (clr_pulse) begin
            flag <= 1'b0;
        end
    end
endmodule

`default_nettype wire

// ===== src/uefp_cts_publish.sv
/*
 * routes the clear-to-send event onto one of the interconnect channels.
 * assumes: cts_event is a one-cycle pulse; channel lines are pulses.
 */
`timescale 1ns/1ps
`default_nettype none

module uefp_cts_publish
    import uefp_pkg::*;
#(
    parameter int NUM_CH = `UEFP_NUM_CHANNELS,
    parameter int CH_W   = `UEFP_CHANNEL_INDEX_W
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              srst,
    // configuration
    input  wire logic              pub_en,
    input  wire logic [CH_W-1:0]   channel_index,
    // event in, channels out
    input  wire logic              cts_event,
    output logic      [NUM_CH-1:0] channel_pulse
);
    // registered so the channel lines are glitch free
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            always_ff @(posedge clk) begin
                if (srst) begin
                    channel_pulse[g] <= 1'b0;
                end else begin
                    channel_pulse[g] <= cts_event && pub_en
                                        && (channel_index == CH_W'(g)); // [R4] [R5]
                end
            end
        end
    endgenerate
endmodule

`default_nettype wire

// ===== dv/uefp_assertions.sv
/* checker for the event-flag and publish block: apb answers, cts routing, irq.
   assumes: bound to uefp_top and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module uefp_assertions
    import uefp_pkg::*;
#(parameter int NUM_CH = 16) (
    // clock and reset
    input wire logic              clk,
    input wire logic              srst,
    // apb
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [31:0]       paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [3:0]        pstrb,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    // events and flow control
    input wire logic              tx_last_byte_done,
    input wire logic              rx_error,
    input wire logic              rx_timeout,
    input wire logic              rx_started,
    input wire logic              tx_started,
    input wire logic              tx_stopped,
    input wire logic              cts_n,
    // outputs
    input wire logic [NUM_CH-1:0] channel_pulse,
    input wire logic              irq
);
    logic        wr;
    logic        bad;
    logic [31:0] pub_sh;
    logic [6:0]  mask_sh;
    assign wr = psel && penable && pwrite;
    assign bad = paddr[31:12] == 20'h0 && !(paddr[11:0] inside {12'h100, 12'h120, 12'h124,
                 12'h144, 12'h14c, 12'h150, 12'h158, 12'h180, 12'h300, 12'h304});
    // shadows of config that is not visible at the ports
    always_ff @(posedge clk) begin
        if (srst) begin
            pub_sh <= 32'h0;
            mask_sh <= 7'h0;
        end else if (wr && paddr == 32'h180) begin
            for (int b = 0; b < 4; b++) if (pstrb[b]) pub_sh[8*b +: 8] <= pwdata[8*b +: 8];
        end else if (wr && paddr == 32'h300 && pstrb[0]) begin
            mask_sh <= pwdata[6:0];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    sequence cts_fall;
        $fell(cts_n) && !wr;
    endsequence
    sequence err_unmasked;
        rx_error && mask_sh[1] && !wr ##1 !wr;
    endsequence
    a_pub_route: assert property (cts_fall |=>
        channel_pulse == ({{(NUM_CH-1){1'b0}}, pub_sh[31]} << pub_sh[3:0])) else $error("bad route");
    a_pulse_once: assert property (channel_pulse != 0 |=> channel_pulse == 0)
        else $error("pulse too long");
    a_err_unmapped: assert property (psel && penable && bad |-> pslverr) else $error("no slverr");
    a_err_mapped: assert property (psel && penable && !bad && paddr[31:12] == 0 |-> !pslverr)
        else $error("false slverr");
    a_read_zero: assert property (psel && penable && !pwrite && bad |-> prdata == 32'h0)
        else $error("unmapped data");
    a_irq_raise: assert property (err_unmasked |=> irq) else $error("irq late");
    a_irq_quiet: assert property ((mask_sh == 7'h0) [*2] |-> !irq) else $error("irq masked");
    a_rst_quiet: assert property ($fell(srst) |-> !irq && channel_pulse == 0)
        else $error("reset outputs");
endmodule
bind uefp_top uefp_assertions #(.NUM_CH(NUM_CH)) u_uefp_chk (.*);
`default_nettype wire

// ===== dv/uefp_remote.sv
/* model of the remote serial device driving the flow-control line.
   assumes: the bench asks with permit; lag sets how slowly it answers. */
`timescale 1ns/1ps
`default_nettype none
module uefp_remote (
    // clock
    input wire logic       clk,
    // request from the bench
    input wire logic       permit,
    input wire logic [3:0] lag,
    // flow control toward the port, low means clear to send
    output logic           cts_n
);
    logic [3:0] cnt_reg;
    initial begin
        cts_n = 1'b1;
        cnt_reg = 4'h0;
    end
    always @(posedge clk) begin
        if (cts_n != permit) cnt_reg <= 4'h0;
        else if (cnt_reg >= lag) cts_n <= !permit;
        else cnt_reg <= cnt_reg + 4'h1;
    end
endmodule
`default_nettype wire

// ===== dv/tb.sv
/* self-checking bench for uefp_top with the remote flow-control model.
   assumes: zero-wait apb slave, pulse event inputs, 250 MHz clock. */
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [5:0]  ev = 6'h0;
    logic        permit = 1'b0;
    logic [3:0]  lag = 4'h0;
    logic        cts_n;
    logic [15:0] channel_pulse;
    logic [15:0] seen = 16'h0;
    logic        irq;
    logic [31:0] rdat;
    logic        rerr;
    int          miscompares = 0;
    int          total_checks = 0;
    int          cycles = 0;
    // rows: event input i sets the register at offs[i] and status bit i
    logic [11:0] offs [6] = '{12'h120, 12'h124, 12'h144, 12'h14c, 12'h150, 12'h158};
    always #2 clk = ~clk;
    always @(posedge clk) if (channel_pulse !== 16'h0) seen <= seen | channel_pulse;
    uefp_top dut (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .tx_last_byte_done(ev[0]), .rx_error(ev[1]), .rx_timeout(ev[2]),
        .rx_started(ev[3]), .tx_started(ev[4]), .tx_stopped(ev[5]), .cts_n(cts_n),
        .channel_pulse(channel_pulse), .irq(irq));
    uefp_remote u_remote (.clk(clk), .permit(permit), .lag(lag), .cts_n(cts_n));
    task end_sim;
        if (miscompares == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task pulse(input int i);
        @(posedge clk);
        ev <= 6'h1 << i;
        @(posedge clk);
        ev <= 6'h0;
    endtask
    // the remote grants l+1 cycles after permit rises, then withdraws again
    task cts_cycle(input logic [3:0] l);
        @(posedge clk);
        lag <= l;
        permit <= 1'b1;
        seen <= 16'h0;
        @(posedge clk);
        while (cts_n !== 1'b0) @(posedge clk);
        repeat (3) @(posedge clk);
        permit <= 1'b0;
        @(posedge clk);
        while (cts_n !== 1'b1) @(posedge clk);
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            end_sim;
        end
    end
    initial begin
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, {20'h0, offs[i]}, 32'h0);
            chk(rdat, 32'h0);
        end
        apb(1'b0, 32'h180, 32'h0);
        chk(rdat, 32'h0);
        apb(1'b1, 32'h300, 32'h7f);
        for (int i = 0; i < 6; i++) begin
            pulse(i);
            apb(1'b0, {20'h0, offs[i]}, 32'h0);
            chk(rdat, 32'h1);
            chk({31'h0, irq}, 32'h1);
            apb(1'b0, 32'h304, 32'h0);
            chk(rdat, 32'h1 << i);
            // even rows clear through the flag, odd rows through status
            if (i % 2 == 0) apb(1'b1, {20'h0, offs[i]}, 32'h0);
            else apb(1'b1, 32'h304, 32'h1 << i);
            apb(1'b0, {20'h0, offs[i]}, 32'h0);
            chk(rdat, 32'h0);
        end
        for (int c = 0; c < 16; c++) begin
            apb(1'b1, 32'h180, 32'h8000_0000 | c);
            cts_cycle(c[3:0]);
            chk({16'h0, seen}, 32'h1 << c);
        end
        apb(1'b1, 32'h180, 32'h0000_0007);
        cts_cycle(4'h2);
        chk({16'h0, seen}, 32'h0);
        apb(1'b0, 32'h100, 32'h0);
        chk(rdat, 32'h1);
        apb(1'b0, 32'h180, 32'h0);
        chk(rdat, 32'h7);
        apb(1'b0, 32'h104, 32'h0);
        chk({31'h0, rerr}, 32'h1);
        chk(rdat, 32'h0);
        apb(1'b1, 32'h300, 32'h0);
        apb(1'b1, 32'h304, 32'h7f);
        pulse(1);
        apb(1'b0, 32'h304, 32'h0);
        chk(rdat, 32'h2);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, 32'h300, 32'h2);
        apb(1'b0, 32'h124, 32'h0);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, 32'h304, 32'h2);
        apb(1'b0, 32'h124, 32'h0);
        chk({31'h0, irq}, 32'h0);
        // mid-run reset with a pending flag and a live mask
        pulse(1);
        @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        apb(1'b0, 32'h304, 32'h0);
        chk(rdat, 32'h0);
        apb(1'b0, 32'h300, 32'h0);
        chk(rdat, 32'h0);
        end_sim;
    end
endmodule
`default_nettype wire
